// >>> pkg/gpenp_pkg.sv
// constants and register layout of the gpio event notification port
package gpenp_pkg;
    localparam int PIN_N = 8;
    // configuration space indices
    localparam logic [7:0] IDX_SEL   = 8'hF0;
    localparam logic [7:0] IDX_CFG1  = 8'hF1;
    localparam logic [7:0] IDX_EVR   = 8'hF2;
    localparam logic [7:0] IDX_CFG2  = 8'hF3;
    localparam logic [7:0] IDX_MODE  = 8'hF8;
    // runtime offsets
    localparam logic [2:0] OFS_DO    = 3'h0;
    localparam logic [2:0] OFS_DI    = 3'h1;
    localparam logic [2:0] OFS_EVEN  = 3'h2;
    localparam logic [2:0] OFS_EVST  = 3'h3;
    localparam logic [2:0] OFS_DIO   = 3'h4;
    // reset values
    localparam logic [7:0] RST_SEL   = 8'h00;
    localparam logic [7:0] RST_CFG1  = 8'h40;
    localparam logic [7:0] RST_EVR   = 8'h01;
    localparam logic [7:0] RST_CFG2  = 8'h00;
    localparam logic [7:0] RST_MODE  = 8'h01;
    localparam logic [7:0] RST_OUT   = 8'hFF;
    localparam logic [7:0] RST_EVEN  = 8'h00;
    localparam logic [7:0] RST_EVST  = 8'h00;
    // field positions
    localparam int C1_OE     = 0;
    localparam int C1_PP     = 1;
    localparam int C1_PU     = 2;
    localparam int C1_LOCK   = 3;
    localparam int C1_TYPE   = 4;
    localparam int C1_POL    = 5;
    localparam int C1_DEB    = 6;
    localparam int C2_LOAD   = 4;
    localparam int EVR_IRQ   = 0;
    localparam int EVR_SMI   = 1;
    localparam int MODE_SEP  = 0;
    localparam int SEL_W     = 3;
    // bits frozen by the lock bit
    localparam logic [7:0] C1_LOCK_MASK = 8'h8F;
    localparam logic [7:0] C2_LOCK_MASK = 8'h10;
    // timing: 1 ms divider tick, 16 ms debounce
    localparam longint CLK_HZ       = 125000000;
    localparam int     TICK_TIME_US = 1000;
    localparam int     TICK_CYC_DEF =
        int'(CLK_HZ * TICK_TIME_US / 1000000);
    localparam int     DEB_TIME_MS  = 16;
    localparam int     DEB_TICKS_DEF = DEB_TIME_MS * 1000 / TICK_TIME_US;
endpackage

// >>> pkg/gpenp_evt_if.sv
// per-pin event detector signals between port core and pin detector
`timescale 1ns/1ps
interface gpenp_evt_if;
    logic lvl;     // filtered synchronised pin level
    logic tick;    // 1 ms enable pulse
    logic deb_en;  // debounce enable
    logic ev_lvl;  // 1 = level event, 0 = edge event
    logic ev_pol;  // 1 = rising / high
    logic hit;     // active edge or level seen this cycle
    modport core (output lvl, tick, deb_en, ev_lvl, ev_pol, input hit);
    modport pin  (input lvl, tick, deb_en, ev_lvl, ev_pol, output hit);
endinterface

// >>> design/gpenp_pin.sv
// per-pin debouncer and edge or level event detector
`timescale 1ns/1ps
module gpenp_pin
    import gpenp_pkg::*;
#(
    parameter int DEB_TICKS = DEB_TICKS_DEF
)
(
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    // event detector link
    gpenp_evt_if.pin    ev
);
    localparam int CW = $clog2(DEB_TICKS + 1);

    logic          deb_q;
    logic          deb_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          prev_q;
    logic          prev_d;
    logic          det;

    // level must stay put for a whole period; any bounce restarts it
    always_comb
    begin
        deb_d = deb_q;
        cnt_d = cnt_q;
        if (ev.lvl == deb_q)
            cnt_d = '0;
        else if (ev.tick)
        begin
            if (cnt_q == CW'(DEB_TICKS - 1))
            begin
                deb_d = ev.lvl;
                cnt_d = '0;
            end
            else
                cnt_d = cnt_q + CW'(1);
        end
        prev_d = det;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            deb_q  <= 1'b1;
            cnt_q  <= '0;
            prev_q <= 1'b1;
        end
        else
        begin
            deb_q  <= deb_d;
            cnt_q  <= cnt_d;
            prev_q <= prev_d;
        end
    end

    // level events fire every cycle while active, so status re-sets
    assign det    = ev.deb_en ? deb_q : ev.lvl;
    assign ev.hit = ev.ev_lvl ? (det == ev.ev_pol)
                  : ((det != prev_q) && (det == ev.ev_pol));
endmodule

// >>> design/gpenp_top.sv
// gpio event notification port: registers, pins and notification
`timescale 1ns/1ps
module gpenp_top
    import gpenp_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC_DEF,
    parameter int DEB_TICKS   = DEB_TICKS_DEF
)
(
    // clock and standby reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // device level status
    input  wire logic             blk_active,
    input  wire logic             main_pwr_ok,
    input  wire logic [PIN_N-1:0] pin_mux_gpio,
    // configuration space access
    input  wire logic             cfg_wr,
    input  wire logic             cfg_rd,
    input  wire logic [7:0]       cfg_index,
    // runtime register access
    input  wire logic             rt_wr,
    input  wire logic             rt_rd,
    input  wire logic [2:0]       rt_offset,
    // shared data
    input  wire logic [7:0]       reg_wdata,
    output logic      [7:0]       reg_rdata,
    // port pins
    input  wire logic [PIN_N-1:0] pin_in,
    output logic      [PIN_N-1:0] pin_out,
    output logic      [PIN_N-1:0] pin_oe,
    output logic      [PIN_N-1:0] pin_pu_en,
    // notification targets
    output logic                  irq_req,
    output logic                  smi_n
);
    localparam int TW = $clog2(TICK_CYCLES);

    // pin synchroniser, three stages and agreement filter
    logic [PIN_N-1:0] sy1_q;
    logic [PIN_N-1:0] sy2_q;
    logic [PIN_N-1:0] sy3_q;
    logic [PIN_N-1:0] lvl_q;
    logic [PIN_N-1:0] lvl_d;

    // divider
    logic [TW-1:0]    tick_cnt_q;
    logic [TW-1:0]    tick_cnt_d;
    logic             tick_q;
    logic             tick_d;

    // configuration sets
    logic [7:0]       sel_q;
    logic [7:0]       sel_d;
    logic [7:0]       mode_q;
    logic [7:0]       mode_d;
    logic [7:0]       cfg1_q [PIN_N];
    logic [7:0]       cfg1_d [PIN_N];
    logic [7:0]       evr_q  [PIN_N];
    logic [7:0]       evr_d  [PIN_N];
    logic [7:0]       cfg2_q [PIN_N];
    logic [7:0]       cfg2_d [PIN_N];

    // runtime registers
    logic [PIN_N-1:0] out_q;
    logic [PIN_N-1:0] out_d;
    logic [PIN_N-1:0] en_q;
    logic [PIN_N-1:0] en_d;
    logic [PIN_N-1:0] st_q;
    logic [PIN_N-1:0] st_d;

    // outputs
    logic [7:0]       rdata_q;
    logic [7:0]       rdata_d;
    logic [PIN_N-1:0] oe_q;
    logic [PIN_N-1:0] oe_d;
    logic [PIN_N-1:0] pu_q;
    logic [PIN_N-1:0] pu_d;
    logic             irq_q;
    logic             irq_d;
    logic             smi_n_q;
    logic             smi_n_d;

    // derived per-pin vectors
    logic [PIN_N-1:0] lock_v;
    logic [PIN_N-1:0] load_v;
    logic [PIN_N-1:0] r_irq_v;
    logic [PIN_N-1:0] r_smi_v;
    logic [PIN_N-1:0] iso_v;
    logic [PIN_N-1:0] in_v;
    logic [PIN_N-1:0] hit_v;
    logic [PIN_N-1:0] pend_v;
    logic [SEL_W-1:0] psel;
    logic             rt_ok;
    logic             sep;

    assign psel  = sel_q[SEL_W-1:0];
    assign rt_ok = blk_active && main_pwr_ok;
    assign sep   = mode_q[MODE_SEP];

    // per-pin slices of the configuration arrays
    always_comb
    begin
        for (int i = 0; i < PIN_N; i++)
        begin
            lock_v[i]  = cfg1_q[i][C1_LOCK];
            load_v[i]  = cfg2_q[i][C2_LOAD];
            r_irq_v[i] = evr_q[i][EVR_IRQ];
            r_smi_v[i] = evr_q[i][EVR_SMI];
        end
    end

    // supply-load pins lose their buffers while main supply is off
    assign iso_v = load_v & {PIN_N{~main_pwr_ok}};
    assign in_v  = lvl_q & ~iso_v;

    // a change counts only once stages two and three agree
    always_comb
    begin
        lvl_d = (~(sy2_q ^ sy3_q) & sy3_q) | ((sy2_q ^ sy3_q) & lvl_q);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sy1_q <= '1;
            sy2_q <= '1;
            sy3_q <= '1;
            lvl_q <= '1;
        end
        else
        begin
            sy1_q <= pin_in;
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
            lvl_q <= lvl_d;
        end
    end

    // 1 ms enable for the debouncers
    always_comb
    begin
        tick_d     = 1'b0;
        tick_cnt_d = tick_cnt_q + TW'(1);
        if (tick_cnt_q == TW'(TICK_CYCLES - 1))
        begin
            tick_cnt_d = '0;
            tick_d     = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_d;
            tick_q     <= tick_d;
        end
    end

    // one detector per pin, fed from the real pin level
    for (genvar g = 0; g < PIN_N; g++)
    begin : g_pin
        gpenp_evt_if ev ();
        assign ev.lvl    = in_v[g];
        assign ev.tick   = tick_q;
        assign ev.deb_en = cfg1_q[g][C1_DEB];
        assign ev.ev_lvl = cfg1_q[g][C1_TYPE];
        assign ev.ev_pol = cfg1_q[g][C1_POL];
        assign hit_v[g]  = ev.hit & ~iso_v[g];
        gpenp_pin #(
            .DEB_TICKS (DEB_TICKS)
        ) u_pin (
            .clk   (clk),
            .rst_n (rst_n),
            .ev    (ev)
        );
    end

    // configuration space writes, indexed through the select register
    always_comb
    begin
        sel_d  = sel_q;
        mode_d = mode_q;
        for (int i = 0; i < PIN_N; i++)
        begin
            cfg1_d[i] = cfg1_q[i];
            evr_d[i]  = evr_q[i];
            cfg2_d[i] = cfg2_q[i];
        end
        if (cfg_wr)
        begin
            case (cfg_index)
                IDX_SEL:  sel_d = reg_wdata;
                IDX_MODE: mode_d = reg_wdata;
                IDX_EVR:  evr_d[psel] = reg_wdata;
                IDX_CFG1:
                begin
                    if (lock_v[psel])
                        cfg1_d[psel] = (cfg1_q[psel] & C1_LOCK_MASK)
                                     | (reg_wdata & ~C1_LOCK_MASK);
                    else
                        cfg1_d[psel] = reg_wdata;
                end
                IDX_CFG2:
                begin
                    if (lock_v[psel])
                        cfg2_d[psel] = (cfg2_q[psel] & C2_LOCK_MASK)
                                     | (reg_wdata & ~C2_LOCK_MASK);
                    else
                        cfg2_d[psel] = reg_wdata;
                end
                default: ;
            endcase
        end
    end

    // standby reset only; main supply loss keeps configuration
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_q  <= RST_SEL;
            mode_q <= RST_MODE;
            for (int i = 0; i < PIN_N; i++)
            begin
                cfg1_q[i] <= RST_CFG1;
                evr_q[i]  <= RST_EVR;
                cfg2_q[i] <= RST_CFG2;
            end
        end
        else
        begin
            sel_q  <= sel_d;
            mode_q <= mode_d;
            for (int i = 0; i < PIN_N; i++)
            begin
                cfg1_q[i] <= cfg1_d[i];
                evr_q[i]  <= evr_d[i];
                cfg2_q[i] <= cfg2_d[i];
            end
        end
    end

    // runtime writes: blocked while inactive, limited in common mode
    always_comb
    begin
        logic wr;
        logic [PIN_N-1:0] clr;
        wr   = rt_wr && rt_ok;
        clr  = '0;
        out_d = out_q;
        en_d  = en_q;
        if (wr && (rt_offset == OFS_DIO || (sep && rt_offset == OFS_DO)))
            out_d = (out_q & lock_v) | (reg_wdata & ~lock_v);
        if (wr && sep && rt_offset == OFS_EVEN)
            en_d = reg_wdata;
        if (wr && sep && rt_offset == OFS_EVST)
            clr = reg_wdata;
        // a new event beats a clear in the same cycle
        st_d = (st_q & ~clr) | hit_v;
        st_d = st_d & ~iso_v;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_q <= RST_OUT;
            en_q  <= RST_EVEN;
            st_q  <= RST_EVST;
        end
        else
        begin
            out_q <= out_d;
            en_q  <= en_d;
            st_q  <= st_d;
        end
    end

    assign pend_v = st_q & en_q;

    // pin drive and notification targets
    always_comb
    begin
        for (int i = 0; i < PIN_N; i++)
        begin
            // open drain only pulls low; a 1 releases the pin
            oe_d[i] = cfg1_q[i][C1_OE] && pin_mux_gpio[i] && !iso_v[i]
                   && (cfg1_q[i][C1_PP] || !out_q[i]);
            pu_d[i] = cfg1_q[i][C1_PU] && !iso_v[i];
        end
        // serializer picks the irq slot; this is only the request level
        irq_d   = |(pend_v & r_irq_v) && rt_ok;
        smi_n_d = ~|(pend_v & r_smi_v);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oe_q    <= '0;
            pu_q    <= '0;
            irq_q   <= 1'b0;
            smi_n_q <= 1'b1;
        end
        else
        begin
            oe_q    <= oe_d;
            pu_q    <= pu_d;
            irq_q   <= irq_d;
            smi_n_q <= smi_n_d;
        end
    end

    // read data, registered one cycle after the read strobe
    always_comb
    begin
        rdata_d = rdata_q;
        if (cfg_rd)
        begin
            case (cfg_index)
                IDX_SEL:  rdata_d = sel_q;
                IDX_CFG1: rdata_d = cfg1_q[psel];
                IDX_EVR:  rdata_d = evr_q[psel];
                IDX_CFG2: rdata_d = cfg2_q[psel];
                IDX_MODE: rdata_d = mode_q;
                default:  rdata_d = 8'h00;
            endcase
        end
        else if (rt_rd)
        begin
            if (!rt_ok)
                rdata_d = 8'h00;
            else
            begin
                case (rt_offset)
                    OFS_DO:   rdata_d = out_q;
                    OFS_DI:   rdata_d = in_v;
                    OFS_EVEN: rdata_d = en_q;
                    OFS_EVST: rdata_d = st_q;
                    OFS_DIO:  rdata_d = in_v;
                    default:  rdata_d = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= 8'h00;
        else
            rdata_q <= rdata_d;
    end

    assign reg_rdata = rdata_q;
    assign pin_out   = out_q;
    assign pin_oe    = oe_q;
    assign pin_pu_en = pu_q;
    assign irq_req   = irq_q;
    assign smi_n     = smi_n_q;
endmodule

// >>> sim/gpenp_pins_model.sv
// board circuitry and wire resolution on the eight port pins
`timescale 1ns/1ps
module gpenp_pins_model
(
    // port side
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pu_en,
    // board drive set by the bench
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    // resolved levels back to the port
    output logic      [7:0] pin_in
);
    // board backs off wherever the port drives, so no contention
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else
                pin_in[i] = pin_pu_en[i]; // pull-up, else static pull-down
        end
    end
endmodule

// >>> sim/gpenp_top_checker.sv
// port-level assertions for the notification port
`timescale 1ns/1ps
module gpenp_top_checker
    import gpenp_pkg::*;
(
    // clock and reset
    input wire logic             clk,
    input wire logic             rst_n,
    // inputs watched
    input wire logic             blk_active,
    input wire logic             main_pwr_ok,
    input wire logic             cfg_wr,
    input wire logic             cfg_rd,
    input wire logic [7:0]       cfg_index,
    input wire logic             rt_wr,
    input wire logic             rt_rd,
    input wire logic [2:0]       rt_offset,
    input wire logic [7:0]       reg_wdata,
    // outputs watched
    input wire logic [7:0]       reg_rdata,
    input wire logic [PIN_N-1:0] pin_out,
    input wire logic             irq_req
);
    logic       blk_ok;
    logic [7:0] sel_d;
    logic [7:0] sel_q;
    logic       mode_d;
    logic       mode_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    assign blk_ok = blk_active && main_pwr_ok;
    // shadow of select and mode, kept apart from the design's copy
    always_comb
    begin
        sel_d = sel_q;
        mode_d = mode_q;
        if (cfg_wr && cfg_index == IDX_SEL)
            sel_d = reg_wdata;
        if (cfg_wr && cfg_index == IDX_MODE)
            mode_d = reg_wdata[MODE_SEP];
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_q <= RST_SEL;
            mode_q <= RST_MODE[MODE_SEP];
        end
        else
        begin
            sel_q <= sel_d;
            mode_q <= mode_d;
        end
    end
    // two blocked cycles cover a registered or a gated output alike
    sequence s_blocked;
        !blk_ok [*2];
    endsequence
    sequence s_rt_read;
        rt_rd && !cfg_rd && !cfg_wr;
    endsequence
    irq_off_a: assert property (s_blocked |-> !irq_req)
        else $error("irq asserted while block unavailable");
    irq_rise_a: assert property ($rose(irq_req) |-> $past(blk_ok))
        else $error("irq rose without an active block");
    rdata_hold_a: assert property (!cfg_rd && !rt_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    blocked_read_a: assert property (s_rt_read ##0 !blk_ok |=>
        reg_rdata == 8'h00) else $error("blocked read not zero");
    unmapped_read_a: assert property (s_rt_read ##0 rt_offset > OFS_DIO
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    out_hold_a: assert property (!rt_wr |=> $stable(pin_out))
        else $error("output value moved without a write");
    common_lock_a: assert property (rt_wr && !mode_q &&
        rt_offset != OFS_DIO |=> $stable(pin_out))
        else $error("common mode write reached output value");
    blocked_write_a: assert property (rt_wr && !blk_ok |=>
        $stable(pin_out)) else $error("blocked write reached output");
    sel_read_a: assert property (cfg_rd && cfg_index == IDX_SEL |=>
        reg_rdata == $past(sel_q)) else $error("pin select read wrong");
endmodule
bind gpenp_top gpenp_top_checker gpenp_top_checker_inst (.clk(clk),
    .rst_n(rst_n), .blk_active(blk_active), .main_pwr_ok(main_pwr_ok),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_index(cfg_index),
    .rt_wr(rt_wr), .rt_rd(rt_rd), .rt_offset(rt_offset),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_out(pin_out),
    .irq_req(irq_req));

// >>> sim/gpenp_top_tb.sv
// self-checking bench for the notification port
`timescale 1ns/1ps
module gpenp_top_tb
    import gpenp_pkg::*;
;
    logic       clk, rst_n, blk_active, main_pwr_ok;
    logic       cfg_wr, cfg_rd, rt_wr, rt_rd, irq_req, smi_n;
    logic [7:0] pin_mux_gpio, cfg_index, reg_wdata, reg_rdata;
    logic [7:0] pin_in, pin_out, pin_oe, pin_pu_en, ext_val, ext_en;
    logic [2:0] rt_offset;
    int         n_errors, checked, cycles;
    logic [7:0] idx_tab[5] = '{IDX_SEL, IDX_CFG1, IDX_EVR, IDX_CFG2, IDX_MODE};
    logic [7:0] rst_tab[5] = '{RST_SEL, RST_CFG1, RST_EVR, RST_CFG2, RST_MODE};
    // short counts keep the debounce within a few dozen cycles
    gpenp_top #(.TICK_CYCLES(4), .DEB_TICKS(2)) gpenp_top_inst (.clk(clk),
        .rst_n(rst_n), .blk_active(blk_active), .main_pwr_ok(main_pwr_ok),
        .pin_mux_gpio(pin_mux_gpio), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_index(cfg_index), .rt_wr(rt_wr), .rt_rd(rt_rd),
        .rt_offset(rt_offset), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pu_en(pin_pu_en), .irq_req(irq_req), .smi_n(smi_n));
    gpenp_pins_model gpenp_pins_model_inst (.pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pu_en(pin_pu_en), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in));
    task automatic final_report();
        if (n_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // kind 0 cfg write, 1 cfg read, 2 rt write, 3 rt read; one-cycle strobe
    task automatic bus(input int kind, input logic [7:0] a,
                       input logic [7:0] d);
        @(negedge clk);
        {rt_rd, rt_wr, cfg_rd, cfg_wr} = 4'h1 << kind;
        cfg_index = a;
        rt_offset = a[2:0];
        reg_wdata = d;
        @(negedge clk);
        {rt_rd, rt_wr, cfg_rd, cfg_wr} = 4'h0;
    endtask
    task automatic cw(input logic [7:0] a, input logic [7:0] d);
        bus(0, a, d);
    endtask
    task automatic cr(input logic [7:0] a, input logic [7:0] e);
        bus(1, a, 8'h00);
        check(reg_rdata, e);
    endtask
    task automatic rw(input logic [2:0] a, input logic [7:0] d);
        bus(2, {5'h00, a}, d);
    endtask
    task automatic rr(input logic [2:0] a, input logic [7:0] e);
        bus(3, {5'h00, a}, 8'h00);
        check(reg_rdata, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    function automatic logic [7:0] notif();
        return {6'h00, irq_req, smi_n};
    endfunction
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // hang guard, far above the roughly 250 cycles the tests take
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            n_errors++;
            final_report();
        end
    end
    initial
    begin
        {rst_n, cfg_wr, cfg_rd, rt_wr, rt_rd} = 5'h00;
        {blk_active, main_pwr_ok} = 2'b11;
        {pin_mux_gpio, ext_val, ext_en} = {3{8'hFF}};
        {cfg_index, reg_wdata, rt_offset} = 19'h00000;
        {n_errors, checked, cycles} = '0;
        idle(12);
        rst_n = 1'b1;
        for (int i = 0; i < 5; i++)
            cr(idx_tab[i], rst_tab[i]);
        rr(OFS_DO, RST_OUT);
        rr(OFS_DIO, 8'hFF);
        rr(OFS_EVEN, RST_EVEN);
        rr(OFS_EVST, RST_EVST);
        // pin sets seen through the select register
        cw(IDX_SEL, 8'h03);
        cw(IDX_CFG1, 8'h01);
        cw(IDX_SEL, 8'h00);
        cr(IDX_CFG1, RST_CFG1);
        cw(IDX_SEL, 8'h03);
        cr(IDX_CFG1, 8'h01);
        // software notification through pin 0 output, edge falling
        cw(IDX_SEL, 8'h00);
        cw(IDX_CFG1, 8'h03);
        rw(OFS_DO, 8'hFE);
        idle(8);
        check(pin_oe, 8'h01);
        rr(OFS_DI, 8'hFE);
        rr(OFS_EVST, 8'h01);
        check(notif(), 8'h01);
        cw(IDX_EVR, 8'h03);
        rw(OFS_EVEN, 8'h01);
        idle(3);
        check(notif(), 8'h02);
        blk_active = 1'b0;
        idle(3);
        check(notif(), 8'h00);
        rr(OFS_EVST, 8'h00);
        rw(OFS_EVST, 8'h01);
        blk_active = 1'b1;
        idle(3);
        check(notif(), 8'h02);
        rw(OFS_EVST, 8'h00);
        idle(3);
        check(notif(), 8'h02);
        rw(OFS_EVST, 8'h01);
        idle(3);
        check(notif(), 8'h01);
        // level event on pin 1 from the board, routed to smi only
        cw(IDX_SEL, 8'h01);
        cw(IDX_CFG1, 8'h10);
        cw(IDX_EVR, 8'h02);
        rr(OFS_EVST, 8'h00);
        ext_val[1] = 1'b0;
        rw(OFS_EVEN, 8'h02);
        idle(8);
        check(notif(), 8'h00);
        rw(OFS_EVST, 8'h02);
        idle(3);
        rr(OFS_EVST, 8'h02);
        ext_val[1] = 1'b1;
        idle(8);
        rw(OFS_EVST, 8'h02);
        idle(3);
        check(notif(), 8'h01);
        // lock on pin 0 freezes its output bit and the lock-masked bits of its config
        cw(IDX_SEL, 8'h00);
        cw(IDX_CFG1, 8'h0B);
        rw(OFS_DO, 8'hF9);
        rr(OFS_DO, 8'hF8);
        cw(IDX_CFG1, 8'h00);
        cr(IDX_CFG1, 8'h0B);
        // common data mode: only the combined register writes
        cw(IDX_MODE, 8'h00);
        rw(OFS_DO, 8'h0F);
        rr(OFS_DO, 8'hF8);
        rw(OFS_DIO, 8'hAF);
        rr(OFS_DO, 8'hAE);
        rw(OFS_EVEN, 8'h00);
        rr(OFS_EVEN, 8'h02);
        cw(IDX_MODE, RST_MODE);
        // supply loss clears status of the supply-load pin 2 only
        cw(IDX_SEL, 8'h02);
        cw(IDX_CFG1, 8'h04);
        cw(IDX_CFG2, 8'h10);
        cw(IDX_SEL, 8'h03);
        cw(IDX_CFG1, 8'h00);
        ext_val[3:2] = 2'b00;
        idle(8);
        rr(OFS_EVST, 8'h0C);
        check(pin_pu_en, 8'h04);
        main_pwr_ok = 1'b0;
        idle(4);
        check(pin_pu_en, 8'h00);
        main_pwr_ok = 1'b1;
        idle(8);
        rr(OFS_EVST, 8'h08);
        // debounced rising edge on pin 4; a short wait must not show it
        cw(IDX_SEL, 8'h04);
        cw(IDX_CFG1, 8'h60);
        ext_val[4] = 1'b0;
        idle(20);
        ext_val[4] = 1'b1;
        idle(4);
        rr(OFS_EVST, 8'h08);
        idle(20);
        rr(OFS_EVST, 8'h18);
        cr(8'hF5, 8'h00);
        rr(3'h7, 8'h00);
        // pin muxed away from the port stops the drive
        pin_mux_gpio[0] = 1'b0;
        idle(2);
        check(pin_oe, 8'h00);
        final_report();
    end
endmodule
